/* File: cdc_average_channel.sv */
// one channel of exponential data averaging
// assumes the conversion pulse is one cycle on i_clk
`timescale 1ns/1ps
module cdc_average_channel (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   input  wire cdc_setup_pkg::conv_t      i_conv,
   input  wire logic [4:0]                i_log2_tc,
   output logic      [15:0]               o_average
);
   // ======================================================
   // fixed point average: 16 integer bits plus 16 fraction bits
   logic [31:0] avg_reg;
   logic [31:0] avg_next;
   logic signed [33:0] diff;
   logic signed [33:0] step;

   always_comb begin
      diff     = $signed({2'h0, i_conv.data, 16'h0000}) - $signed({2'h0, avg_reg});
      // a step of diff/tc per conversion gives exp(-n/tc) settling
      step     = diff >>> i_log2_tc;
      avg_next = 32'(($signed({2'h0, avg_reg}) + step));
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         avg_reg <= 32'h0000_0000;
      end else if (i_conv.valid) begin
         avg_reg <= avg_next;
      end
   end

   assign o_average = avg_reg[31:16];
endmodule

/* File: cdc_channel_setup_averaging.sv */
// two-channel setup register bank with per-channel data averaging
// assumes apb master on i_clk; conversion pulses are synchronous to i_clk
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module cdc_channel_setup_averaging (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [9:0]                i_paddr,
   input  wire logic [31:0]               i_pwdata,
   input  wire cdc_setup_pkg::conv_t      i_conv_one,
   input  wire cdc_setup_pkg::conv_t      i_conv_two,
   output logic      [31:0]               o_prdata,
   output logic                           o_pready,
   output logic                           o_pslverr,
   output cdc_setup_pkg::chan_cfg_t       o_cfg_one,
   output cdc_setup_pkg::chan_cfg_t       o_cfg_two,
   output logic                           o_fixed_threshold_select,
   output logic      [15:0]               o_average_one,
   output logic      [15:0]               o_average_two
);
   // ======================================================
   // apb decode; slave answers in the second access cycle, after one wait state
   // writes land on the completing edge so the master sees them only once ready is up
   logic [7:0]  setup_one_reg;
   logic [7:0]  setup_two_reg;
   logic [7:0]  control_reg;
   logic [15:0] avg_one;
   logic [15:0] avg_two;
   logic [7:0]  idx;
   logic        hit_map;
   logic        access;
   logic        wr;
   logic [31:0] rdata_next;

   assign idx    = i_paddr[9:2];
   assign access = i_psel && i_penable && !o_pready;
   assign wr     = i_psel && i_penable && o_pready && i_pwrite && hit_map;

   always_comb begin
      hit_map    = 1'b1;
      rdata_next = 32'h0000_0000;
      unique case (idx)
         cdc_setup_pkg::SETUP_ONE_IDX: rdata_next = {24'h000000, setup_one_reg};
         cdc_setup_pkg::SETUP_TWO_IDX: rdata_next = {24'h000000, setup_two_reg};
         cdc_setup_pkg::CONTROL_IDX:   rdata_next = {24'h000000, control_reg};
         cdc_setup_pkg::AVG_ONE_IDX:   rdata_next = {16'h0000, avg_one};
         cdc_setup_pkg::AVG_TWO_IDX:   rdata_next = {16'h0000, avg_two};
         default:                      hit_map    = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else begin
         o_pready  <= access;
         o_pslverr <= access && !hit_map;
         o_prdata  <= (access && !i_pwrite) ? rdata_next : 32'h0000_0000;
      end
   end

   // ======================================================
   // setup registers, one per channel, and the control register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         setup_one_reg <= cdc_setup_pkg::SETUP_RESET;
      end else if (wr && idx == cdc_setup_pkg::SETUP_ONE_IDX) begin
         setup_one_reg <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         setup_two_reg <= cdc_setup_pkg::SETUP_RESET;
      end else if (wr && idx == cdc_setup_pkg::SETUP_TWO_IDX) begin
         setup_two_reg <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         control_reg <= cdc_setup_pkg::CONTROL_RESET;
      end else if (wr && idx == cdc_setup_pkg::CONTROL_IDX) begin
         control_reg <= i_pwdata[7:0];
      end
   end

   // ======================================================
   // field decode
   function automatic cdc_setup_pkg::chan_cfg_t decode(input logic [7:0] s, input logic fixed);
      cdc_setup_pkg::chan_cfg_t c;
      c = '0;
      unique case (s[cdc_setup_pkg::RANGE_MSB:cdc_setup_pkg::RANGE_LSB])
         cdc_setup_pkg::RANGE_2PF: begin
            c.range_quarter_pf = cdc_setup_pkg::RANGE_Q_2PF;
            c.dac_step         = cdc_setup_pkg::STEP_2PF;
         end
         cdc_setup_pkg::RANGE_HALF_PF: begin
            c.range_quarter_pf = cdc_setup_pkg::RANGE_Q_HALF;
            c.dac_step         = cdc_setup_pkg::STEP_HALF_PF;
         end
         cdc_setup_pkg::RANGE_1PF: begin
            c.range_quarter_pf = cdc_setup_pkg::RANGE_Q_1PF;
            c.dac_step         = cdc_setup_pkg::STEP_1PF;
         end
         cdc_setup_pkg::RANGE_4PF: begin
            c.range_quarter_pf = cdc_setup_pkg::RANGE_Q_4PF;
            c.dac_step         = cdc_setup_pkg::STEP_4PF;
         end
      endcase
      c.hyst_active     = s[cdc_setup_pkg::HYST_BIT] && !fixed;
      c.time_const_log2 = {1'b0, s[cdc_setup_pkg::SETTLE_MSB:0]} + 5'h01;
      return c;
   endfunction

   logic fixed_sel;
   assign fixed_sel = control_reg[cdc_setup_pkg::FIXED_BIT];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cfg_one                <= '0;
         o_cfg_two                <= '0;
         o_fixed_threshold_select <= 1'b0;
         o_average_one            <= 16'h0000;
         o_average_two            <= 16'h0000;
      end else begin
         o_cfg_one                <= decode(setup_one_reg, fixed_sel);
         o_cfg_two                <= decode(setup_two_reg, fixed_sel);
         o_fixed_threshold_select <= fixed_sel;
         o_average_one            <= avg_one;
         o_average_two            <= avg_two;
      end
   end

   // ======================================================
   // independent averaging per channel
   logic [4:0] tc_one;
   logic [4:0] tc_two;
   assign tc_one = {1'b0, setup_one_reg[3:0]} + 5'h01;
   assign tc_two = {1'b0, setup_two_reg[3:0]} + 5'h01;

   cdc_average_channel u_avg_one (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_conv    (i_conv_one),
      .i_log2_tc (tc_one),
      .o_average (avg_one)
   );

   cdc_average_channel u_avg_two (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_conv    (i_conv_two),
      .i_log2_tc (tc_two),
      .o_average (avg_two)
   );
endmodule

/* File: cdc_setup_checker.sv */
// concurrent checks on the setup and averaging register bank ports
// assumes a single clock domain with async active-low reset
`timescale 1ns/1ps
module cdc_setup_checker (
   input wire logic                 i_clk,
   input wire logic                 i_rst_n,
   input wire logic                 i_psel,
   input wire logic                 i_penable,
   input wire cdc_setup_pkg::conv_t i_conv_one,
   input wire cdc_setup_pkg::conv_t i_conv_two,
   input wire logic                 o_pready,
   input wire logic                 o_pslverr,
   input wire cdc_setup_pkg::chan_cfg_t o_cfg_one,
   input wire cdc_setup_pkg::chan_cfg_t o_cfg_two,
   input wire logic                 o_fixed_threshold_select,
   input wire logic [15:0]          o_average_one,
   input wire logic [15:0]          o_average_two
);
   // ==================================================
   // properties
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   AST_ANSWER: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("late ready");
   AST_PULSE: assert property (o_pready |=> !o_pready) else $error("ready held");
   AST_ERR_READY: assert property (o_pslverr |-> o_pready) else $error("error without ready");
   AST_STEP_ONE: assert property (o_cfg_one.range_quarter_pf == {o_cfg_one.dac_step, 1'b0}) else $error("step one");
   AST_STEP_TWO: assert property (o_cfg_two.range_quarter_pf == {o_cfg_two.dac_step, 1'b0}) else $error("step two");
   // decode outputs leave their reset zero one edge after release
   AST_TC_SPAN: assert property ($past(i_rst_n) |-> o_cfg_one.time_const_log2 inside {[5'h01:5'h10]}) else $error("tc span");
   AST_TC_SPAN_TWO: assert property ($past(i_rst_n) |-> o_cfg_two.time_const_log2 inside {[5'h01:5'h10]}) else $error("tc span two");
   AST_HYST_FIXED: assert property (o_fixed_threshold_select |-> !o_cfg_one.hyst_active && !o_cfg_two.hyst_active) else $error("hyst");
   AST_AVG_ONE: assert property ($changed(o_average_one) |-> $past(i_conv_one.valid, 2)) else $error("avg one");
   AST_AVG_TWO: assert property ($changed(o_average_two) |-> $past(i_conv_two.valid, 2)) else $error("avg two");
   cover property (o_pslverr);
   cover property (o_cfg_one.hyst_active);
   cover property ($changed(o_average_one));
endmodule
bind cdc_channel_setup_averaging cdc_setup_checker i_cdc_setup_checker (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_conv_one(i_conv_one),
   .i_conv_two(i_conv_two), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_cfg_one(o_cfg_one),
   .o_cfg_two(o_cfg_two), .o_fixed_threshold_select(o_fixed_threshold_select),
   .o_average_one(o_average_one), .o_average_two(o_average_two));

/* File: cdc_setup_pkg.sv */
// package for the two-channel setup and averaging register bank
// assumes an apb master on the same 40 MHz clock; conversion events come from the core
package cdc_setup_pkg;
   // ======================================================
   // register map, byte addresses are four times the index
   localparam logic [7:0]  SETUP_ONE_IDX      = 8'h0B;
   localparam logic [7:0]  SETUP_TWO_IDX      = 8'h0E;
   localparam logic [7:0]  CONTROL_IDX        = 8'h10;
   localparam logic [7:0]  AVG_ONE_IDX        = 8'h11;
   localparam logic [7:0]  AVG_TWO_IDX        = 8'h12;
   localparam logic [7:0]  SETUP_RESET        = 8'h0B;
   localparam logic [7:0]  CONTROL_RESET      = 8'h00;
   // ======================================================
   // field positions
   localparam int          RANGE_MSB          = 7;
   localparam int          RANGE_LSB          = 6;
   localparam int          HYST_BIT           = 4;
   localparam int          SETTLE_MSB         = 3;
   localparam int          FIXED_BIT          = 0;
   // ======================================================
   // range codes: input range in quarter pF and dac step in lsb
   localparam logic [1:0]  RANGE_2PF          = 2'h0;
   localparam logic [1:0]  RANGE_HALF_PF      = 2'h1;
   localparam logic [1:0]  RANGE_1PF          = 2'h2;
   localparam logic [1:0]  RANGE_4PF          = 2'h3;
   localparam logic [4:0]  RANGE_Q_2PF        = 5'h08;
   localparam logic [4:0]  RANGE_Q_HALF       = 5'h02;
   localparam logic [4:0]  RANGE_Q_1PF        = 5'h04;
   localparam logic [4:0]  RANGE_Q_4PF        = 5'h10;
   localparam logic [3:0]  STEP_2PF           = 4'h4;
   localparam logic [3:0]  STEP_HALF_PF       = 4'h1;
   localparam logic [3:0]  STEP_1PF           = 4'h2;
   localparam logic [3:0]  STEP_4PF           = 4'h8;
   // ======================================================
   typedef struct packed {
      logic [4:0]  range_quarter_pf;
      logic [3:0]  dac_step;
      logic        hyst_active;
      logic [4:0]  time_const_log2;
   } chan_cfg_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } conv_t;
endpackage

/* File: tb_cdc_channel_setup_averaging.sv */
// self-checking bench for the setup and averaging register bank
// drives apb and conversion pulses directly, 40 MHz clock
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module tb_cdc_channel_setup_averaging;
   logic i_clk = 1'b0, i_rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, rdata, o_prdata;
   logic o_pready, o_pslverr, o_fixed_threshold_select;
   logic [15:0] o_average_one, o_average_two;
   cdc_setup_pkg::conv_t conv_one = '0, conv_two = '0;
   cdc_setup_pkg::chan_cfg_t o_cfg_one, o_cfg_two;
   int errors = 0, tests_run = 0, cycles = 0;
   cdc_channel_setup_averaging i_cdc_channel_setup_averaging (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_conv_one(conv_one), .i_conv_two(conv_two), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .o_cfg_one(o_cfg_one), .o_cfg_two(o_cfg_two),
      .o_fixed_threshold_select(o_fixed_threshold_select),
      .o_average_one(o_average_one), .o_average_two(o_average_two));
   initial begin
      forever #12.5 i_clk = ~i_clk;
   end
   // ==================================================
   // bus and stimulus helpers
   // only the bench timeout ends the wait for ready; one idle edge before the next setup
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge i_clk); penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      rdata = o_prdata; err = o_pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge i_clk);
   endtask
   // one settle edge so registered decode outputs reflect the write
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
      @(posedge i_clk);
   endtask
   task automatic pulse_one(input logic [15:0] d);
      conv_one <= '{1'b1, d};
      @(posedge i_clk); conv_one.valid <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==================================================
   // scenarios
   task automatic t_reset();
      apb(1'b0, 10'h02C, 32'h0); `CHK(rdata, 32'h0000000B)
      apb(1'b0, 10'h038, 32'h0); `CHK(rdata, 32'h0000000B)
      `CHK({o_cfg_one.range_quarter_pf, o_cfg_one.time_const_log2}, 10'h10C)
      $display("test reset done");
   endtask
   task automatic t_ranges();
      logic [4:0] q [4] = '{5'h08, 5'h02, 5'h04, 5'h10};
      logic [3:0] s [4] = '{4'h4, 4'h1, 4'h2, 4'h8};
      for (int c = 0; c < 4; c++) begin
         wr(10'h02C, {c[1:0], 6'h01});
         `CHK(o_cfg_one.range_quarter_pf, q[c])
         `CHK(o_cfg_one.dac_step, s[c])
         `CHK(o_cfg_two.time_const_log2, 5'h0C)
      end
      wr(10'h02C, 8'h0F); `CHK(o_cfg_one.time_const_log2, 5'h10)
      $display("test ranges done");
   endtask
   task automatic t_hyst();
      wr(10'h038, 8'h10); `CHK(o_cfg_two.hyst_active, 1'b1)
      `CHK({o_cfg_two.range_quarter_pf, o_cfg_two.dac_step}, 9'h084)
      wr(10'h040, 8'h01); `CHK({o_fixed_threshold_select, o_cfg_two.hyst_active}, 2'h2)
      wr(10'h040, 8'h00); `CHK(o_fixed_threshold_select, 1'b0)
      $display("test hyst done");
   endtask
   task automatic t_average();
      wr(10'h02C, 8'h00);
      pulse_one(16'h8000); `CHK(o_average_one, 16'h4000)
      pulse_one(16'h8000); `CHK(o_average_one, 16'h6000)
      `CHK(o_average_two, 16'h0000)
      apb(1'b0, 10'h044, 32'h0); `CHK(rdata, 32'h00006000)
      apb(1'b0, 10'h3FC, 32'h0); `CHK({err, rdata}, 33'h100000000)
      $display("test average done");
   endtask
   task automatic t_midreset();
      wr(10'h02C, 8'h41);
      pulse_one(16'h1000);
      i_rst_n <= 1'b0;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      apb(1'b0, 10'h02C, 32'h0); `CHK(rdata, 32'h0000000B)
      `CHK(o_average_one, 16'h0000)
      $display("test midreset done");
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles > 5000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      t_reset();
      t_ranges();
      t_hyst();
      t_average();
      t_midreset();
      stop_test();
   end
endmodule
